// *** rcu_pkg.sv ***
// Constants, types and register map for the reset controller.
// Assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data.
`default_nettype none
package rcu_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned POR_DELAY_US = 250;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WDT_DIV = 12;
  localparam logic [31:0] ENTRY_ADDR = 32'h0000_0000;
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [11:0] OFS_CAUSE = 12'h000;
  localparam logic [11:0] OFS_MON = 12'h004;
  localparam logic [11:0] OFS_SWRST = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  localparam int unsigned BIT_PIN = 0;
  localparam int unsigned BIT_POR = 1;
  localparam int unsigned BIT_SW = 4;
  localparam int unsigned BIT_MON_EN = 7;
  localparam int unsigned BIT_MON_STAT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_HOLD = 2'b01,
    ST_DELAY = 2'b10,
    ST_RUN = 2'b11
  } rcu_state_t;
  typedef enum logic [1:0] {
    SRC_POR = 2'b00,
    SRC_MON = 2'b01,
    SRC_PIN = 2'b10,
    SRC_SW = 2'b11
  } rcu_src_t;
endpackage : rcu_pkg
`default_nettype wire

// *** rcu_ctl_if.sv ***
// Link between the register slave and the reset sequencer.
// Assumes both ends run on the system clock.
`default_nettype none
interface rcu_ctl_if;
  logic mon_en;
  logic mon_stat;
  logic [7:0] cause;
  logic in_reset;
  logic sw_req;
  logic mon_wr;
  logic mon_wdata;
  modport seq (input sw_req, mon_wr, mon_wdata, output mon_en, mon_stat, cause, in_reset);
  modport regs (output sw_req, mon_wr, mon_wdata, input mon_en, mon_stat, cause, in_reset);
endinterface : rcu_ctl_if
`default_nettype wire

// *** rcu_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs come from pins outside the clock domain.
`default_nettype none
module rcu_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  if (W < 1) begin : g_bad_width
    $error("width must be positive");
  end
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign dout = s2_q;
endmodule : rcu_sync
`default_nettype wire

// *** rcu_seq.sv ***
// Reset sequencer: collects reset causes, times release, keeps cause flags.
// Assumes RST is the power-on event and supply/pin inputs are already synchronised.
`default_nettype none
module rcu_seq
  import rcu_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_DELAY_CYC
) (
  // Clock and power-on
  input wire logic clk,
  input wire logic rst,
  // Synchronised sources
  input wire logic vdd_ok,
  input wire logic pin_low,
  input wire logic other_req,
  // Control
  rcu_ctl_if.seq ctl,
  output logic drive_pin
);
  rcu_state_t st_q, st_d;
  rcu_src_t src_q, src_d;
  logic [31:0] cnt_q, cnt_d;
  logic [7:0] cause_q, cause_d;
  logic mon_en_q, mon_en_d;
  logic mon_trip;
  if (POR_CYC < 1) begin : g_bad_delay
    $error("power-on delay must be at least one cycle");
  end
  assign mon_trip = mon_en_q & ~vdd_ok;
  always_comb begin
    st_d = st_q;
    src_d = src_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    mon_en_d = mon_en_q;
    if (ctl.mon_wr) mon_en_d = ctl.mon_wdata;
    case (st_q)
      ST_POR: begin
        if (vdd_ok) begin
          st_d = ST_DELAY;
          cnt_d = '0;
        end
      end
      ST_DELAY: begin
        if (!vdd_ok) st_d = ST_POR;
        else if (cnt_q >= POR_CYC - 1) begin
          st_d = ST_RUN;
          cause_d = 8'h00;
          cause_d[BIT_POR] = 1'b1;
        end else cnt_d = cnt_q + 32'h0000_0001;
      end
      ST_HOLD: begin
        if (src_q == SRC_MON && vdd_ok) begin
          st_d = ST_RUN;
          cause_d = 8'h00;
        end else if (src_q == SRC_PIN && !pin_low) begin
          st_d = ST_RUN;
          cause_d = 8'h00;
          cause_d[BIT_PIN] = 1'b1;
        end else if (src_q == SRC_SW || src_q == SRC_POR) begin
          st_d = ST_RUN;
          cause_d = 8'h00;
          cause_d[BIT_SW] = (src_q == SRC_SW);
        end
      end
      ST_RUN: begin
        if (mon_trip) begin
          st_d = ST_HOLD;
          src_d = SRC_MON;
        end else if (pin_low) begin
          st_d = ST_HOLD;
          src_d = SRC_PIN;
        end else if (ctl.sw_req || other_req) begin
          st_d = ST_HOLD;
          src_d = other_req ? SRC_POR : SRC_SW;
        end
      end
      default: st_d = ST_POR;
    endcase
  end
  // Asynchronous power-on; everything else leaves reset on clock edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_POR;
      src_q <= SRC_POR;
      cnt_q <= '0;
      cause_q <= 8'h00;
      mon_en_q <= 1'b1;
    end else begin
      st_q <= st_d;
      src_q <= src_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      mon_en_q <= mon_en_d;
    end
  end
  assign ctl.in_reset = (st_q != ST_RUN);
  assign ctl.cause = cause_q;
  assign ctl.mon_en = mon_en_q;
  assign ctl.mon_stat = vdd_ok;
  assign drive_pin = (st_q == ST_POR) || (st_q == ST_DELAY) ||
                     (st_q == ST_HOLD && src_q == SRC_MON);
endmodule : rcu_seq
`default_nettype wire

// *** rcu_top.sv ***
// Reset controller top: AXI4-Lite register slave, pin synchronisers, core restart outputs.
// Assumes RST comes from the power-on detector and CORE_CLK runs at 40 MHz.
`default_nettype none
module rcu_top
  import rcu_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_DELAY_CYC
) (
  // Clock and power-on reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Supply monitor and reset pin
  input wire logic VDD_ABOVE_THRESHOLD,
  input wire logic RESET_PIN_N_IN,
  output logic RESET_PIN_N_OUT,
  output logic RESET_PIN_OE,
  input wire logic OTHER_RESET_REQ,
  // Core restart controls
  output logic CORE_HALT,
  output logic REG_INIT,
  output logic IRQ_TIMER_DISABLE,
  output logic [31:0] PC_LOAD,
  output logic [7:0] SP_LOAD,
  output logic [7:0] PORT_LATCH,
  output logic PORT_OPEN_DRAIN,
  output logic PORT_PULLUP_EN,
  output logic INT_OSC_SEL,
  output logic WDT_EN,
  output logic WDT_TICK,
  // AXI4-Lite slave
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  rcu_ctl_if ctl ();
  logic vdd_ok;
  logic pin_low;
  logic other_req;
  logic drive_pin;
  // Pin sense ignored until the synchroniser has flushed the device's own drive
  logic drv1_q, drv1_d, drv2_q, drv2_d;
  rcu_sync #(.W(3), .RST_VAL(3'b000)) u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .din({VDD_ABOVE_THRESHOLD, ~RESET_PIN_N_IN, OTHER_RESET_REQ}),
    .dout({vdd_ok, pin_low, other_req})
  );
  rcu_seq #(.POR_CYC(POR_CYC)) u_seq (
    .clk(CORE_CLK),
    .rst(RST),
    .vdd_ok(vdd_ok),
    .pin_low(pin_low & ~(drive_pin | drv1_q | drv2_q)),
    .other_req(other_req),
    .ctl(ctl.seq),
    .drive_pin(drive_pin)
  );
  // Reset pin: open-drain pull low
  assign RESET_PIN_N_OUT = 1'b0;
  assign RESET_PIN_OE = drive_pin;
  // Restart state held while in reset
  logic rst_q, rst_d;
  logic [3:0] wdiv_q, wdiv_d;
  logic tick_q, tick_d;
  always_comb begin
    rst_d = ctl.in_reset;
    drv1_d = drive_pin;
    drv2_d = drv1_q;
    wdiv_d = wdiv_q;
    tick_d = 1'b0;
    if (ctl.in_reset) wdiv_d = 4'h0;
    else if (wdiv_q == 4'(WDT_DIV - 1)) begin
      wdiv_d = 4'h0;
      tick_d = 1'b1;
    end else wdiv_d = wdiv_q + 4'h1;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rst_q <= 1'b1;
      drv1_q <= 1'b1;
      drv2_q <= 1'b1;
      wdiv_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      rst_q <= rst_d;
      drv1_q <= drv1_d;
      drv2_q <= drv2_d;
      wdiv_q <= wdiv_d;
      tick_q <= tick_d;
    end
  end
  assign CORE_HALT = rst_q;
  assign REG_INIT = rst_q;
  assign IRQ_TIMER_DISABLE = rst_q;
  assign PC_LOAD = ENTRY_ADDR;
  assign SP_LOAD = SP_RST;
  assign PORT_LATCH = PORT_LATCH_RST;
  assign PORT_OPEN_DRAIN = 1'b1;
  assign PORT_PULLUP_EN = 1'b1;
  assign INT_OSC_SEL = 1'b1;
  assign WDT_EN = ~rst_q;
  assign WDT_TICK = tick_q;
  // AXI4-Lite write channel
  logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic [1:0] bresp_q, bresp_d;
  logic do_wr;
  function automatic logic addr_ok(input logic [11:0] a);
    return a == OFS_CAUSE || a == OFS_MON || a == OFS_SWRST || a == OFS_STAT;
  endfunction : addr_ok
  assign AWREADY = ~aw_got_q & ~bvalid_q;
  assign WREADY = ~w_got_q & ~bvalid_q;
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_wr = 1'b0;
    if (AWVALID && AWREADY) begin
      aw_got_d = 1'b1;
      awaddr_d = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_got_d = 1'b1;
      wdata_d = WDATA;
      wstrb0_d = WSTRB[0];
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      do_wr = wstrb0_q;
      bvalid_d = 1'b1;
      bresp_d = addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
    end
    if (bvalid_q && BREADY) bvalid_d = 1'b0;
  end
  assign ctl.mon_wr = do_wr && awaddr_q == OFS_MON;
  assign ctl.mon_wdata = wdata_q[BIT_MON_EN];
  assign ctl.sw_req = do_wr && awaddr_q == OFS_SWRST && wdata_q[0];
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  // AXI4-Lite read channel
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  assign ARREADY = ~rvalid_q;
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ARVALID && ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (ARADDR)
        OFS_CAUSE: rdata_d[7:0] = ctl.cause;
        OFS_MON: begin
          rdata_d[BIT_MON_EN] = ctl.mon_en;
          rdata_d[BIT_MON_STAT] = ctl.mon_stat;
        end
        OFS_SWRST: rdata_d = 32'h0000_0000;
        OFS_STAT: rdata_d[0] = ctl.in_reset;
        default: rresp_d = RESP_SLVERR;
      endcase
    end else if (rvalid_q && RREADY) rvalid_d = 1'b0;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
endmodule : rcu_top
`default_nettype wire

// *** rcu_top_assertions.sv ***
// Concurrent checks on the reset controller top ports.
// Assumes it is bound into rcu_top and receives its POR_CYC parameter.
`default_nettype none
module rcu_top_assertions #(
  parameter int unsigned POR_CYC = rcu_pkg::POR_DELAY_CYC
) (
  // Clock and power-on reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Supply and pin
  input wire logic VDD_ABOVE_THRESHOLD,
  input wire logic RESET_PIN_OE,
  // Restart controls
  input wire logic CORE_HALT,
  input wire logic REG_INIT,
  input wire logic IRQ_TIMER_DISABLE,
  input wire logic [31:0] PC_LOAD,
  input wire logic [7:0] SP_LOAD,
  input wire logic [7:0] PORT_LATCH,
  input wire logic PORT_OPEN_DRAIN,
  input wire logic PORT_PULLUP_EN,
  input wire logic INT_OSC_SEL,
  input wire logic WDT_EN,
  input wire logic WDT_TICK
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcu_pkg::*;
  logic ran_q, ran_d, seen_q, seen_d;
  logic [15:0] vcnt_q, vcnt_d;
  logic [3:0] gap_q, gap_d;
  // Ran once since power-on, supply-high count, watchdog tick spacing
  always_comb begin
    ran_d = ran_q | ~CORE_HALT;
    vcnt_d = VDD_ABOVE_THRESHOLD ? vcnt_q + 16'h1 : 16'h0;
    gap_d = WDT_TICK ? 4'h0 : gap_q + 4'h1;
    seen_d = WDT_EN & (seen_q | WDT_TICK);
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ran_q <= 1'b0;
      vcnt_q <= 16'h0;
      gap_q <= 4'h0;
      seen_q <= 1'b0;
    end else begin
      ran_q <= ran_d;
      vcnt_q <= vcnt_d;
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  chk_pin_halt: assert property (RESET_PIN_OE |=> CORE_HALT)
    else $error("pin driven without core halt");
  chk_halt_group: assert property (REG_INIT == CORE_HALT && IRQ_TIMER_DISABLE == CORE_HALT)
    else $error("halt group split");
  chk_wdt_run: assert property (WDT_EN != CORE_HALT)
    else $error("watchdog enable wrong");
  chk_tick_en: assert property (WDT_TICK |-> WDT_EN)
    else $error("tick while watchdog off");
  chk_wdt_gap: assert property (WDT_TICK && seen_q |-> gap_q == WDT_DIV - 1)
    else $error("tick spacing wrong");
  chk_restart_vals: assert property (
      PC_LOAD == ENTRY_ADDR && SP_LOAD == SP_RST && INT_OSC_SEL)
    else $error("restart values wrong");
  chk_port_state: assert property (
      PORT_LATCH == PORT_LATCH_RST && PORT_OPEN_DRAIN && PORT_PULLUP_EN)
    else $error("port state wrong");
  chk_por_delay: assert property (
      $fell(CORE_HALT) && !ran_q |-> vcnt_q >= POR_CYC && vcnt_q <= POR_CYC + 8)
    else $error("power-on release delay wrong");
  chk_mon_release: assert property (
      $rose(VDD_ABOVE_THRESHOLD) && ran_q && CORE_HALT |-> ##[1:8] !CORE_HALT)
    else $error("monitor release late");
  cov_por_exit: cover property ($fell(CORE_HALT) && !ran_q);
  cov_mon_reset: cover property ($rose(RESET_PIN_OE) && ran_q);
  cov_wdt_tick: cover property (WDT_TICK && seen_q);
endmodule : rcu_top_assertions
bind rcu_top rcu_top_assertions #(.POR_CYC(POR_CYC)) rcu_top_assertions_i (
  .CORE_CLK, .RST, .VDD_ABOVE_THRESHOLD, .RESET_PIN_OE, .CORE_HALT, .REG_INIT,
  .IRQ_TIMER_DISABLE, .PC_LOAD, .SP_LOAD, .PORT_LATCH, .PORT_OPEN_DRAIN,
  .PORT_PULLUP_EN, .INT_OSC_SEL, .WDT_EN, .WDT_TICK
);
`default_nettype wire

// *** rcu_ext_model.sv ***
// External reset circuitry: the pulled-up open-drain reset line.
// Assumes the device drives through an output enable and the bench can pull low.
`default_nettype none
module rcu_ext_model (
  // Pin drivers
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic ext_low,
  // Resolved line
  output logic pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins unless a party pulls low
  assign pin_n = ((dev_oe && !dev_out) || ext_low) ? 1'b0 : 1'b1;
endmodule : rcu_ext_model
`default_nettype wire

// *** mcu_reset_controller_tb.sv ***
// Self-checking bench for the reset controller top.
// Assumes rcu_pkg, the checker bind and the reset line model are compiled first.
`default_nettype none
module mcu_reset_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcu_pkg::*;
  localparam int POR = 20;
  logic CORE_CLK = 1'b0, RST = 1'b1, VDD_ABOVE_THRESHOLD = 1'b0, OTHER_RESET_REQ = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic ext_low = 1'b0;
  logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
  logic [31:0] WDATA = 32'h0, seed = 32'h2D4C;
  logic [3:0] WSTRB = 4'h0;
  logic RESET_PIN_N_IN, RESET_PIN_N_OUT, RESET_PIN_OE, CORE_HALT, REG_INIT;
  logic IRQ_TIMER_DISABLE, PORT_OPEN_DRAIN, PORT_PULLUP_EN, INT_OSC_SEL, WDT_EN, WDT_TICK;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [31:0] PC_LOAD, RDATA;
  logic [7:0] SP_LOAD, PORT_LATCH;
  int comparisons = 0, miscompares = 0;
  rcu_top #(.POR_CYC(POR)) rcu_top_i (
    .CORE_CLK, .RST, .VDD_ABOVE_THRESHOLD, .RESET_PIN_N_IN, .RESET_PIN_N_OUT, .RESET_PIN_OE,
    .OTHER_RESET_REQ, .CORE_HALT, .REG_INIT, .IRQ_TIMER_DISABLE, .PC_LOAD, .SP_LOAD,
    .PORT_LATCH, .PORT_OPEN_DRAIN, .PORT_PULLUP_EN, .INT_OSC_SEL, .WDT_EN, .WDT_TICK,
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY
  );
  rcu_ext_model rcu_ext_model_i (
    .dev_oe(RESET_PIN_OE), .dev_out(RESET_PIN_N_OUT), .ext_low(ext_low), .pin_n(RESET_PIN_N_IN)
  );
  always #12.5 CORE_CLK = ~CORE_CLK;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] mon_exp(input logic en);
    return {24'h0, en, 1'b1, 6'h0};
  endfunction : mon_exp
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    check("bresp", BRESP, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    check("rresp", RRESP, er);
    check("rdata", RDATA, ed);
  endtask : rd
  task automatic wait_halt(input logic v, output int n);
    n = 0;
    while (CORE_HALT !== v) begin
      @(posedge CORE_CLK);
      n++;
    end
  endtask : wait_halt
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    miscompares++;
    results();
  end
  initial begin
    int n;
    logic en;
    en = 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    repeat (30) @(posedge CORE_CLK);
    check("halt_low_supply", CORE_HALT, 1'b1);
    check("pin_drive_por", RESET_PIN_OE, 1'b1);
    check("reset_group", {REG_INIT, IRQ_TIMER_DISABLE, WDT_EN}, 3'b110);
    VDD_ABOVE_THRESHOLD <= 1'b1;
    wait_halt(1'b0, n);
    check("por_delay", n >= POR, 1'b1);
    check("wdt_on", WDT_EN, 1'b1);
    check("pin_free", RESET_PIN_OE, 1'b0);
    check("por_delay_max", n <= POR + 8, 1'b1);
    check("pc_load", PC_LOAD, ENTRY_ADDR);
    check("sp_load", SP_LOAD, SP_RST);
    check("port_latch", PORT_LATCH, PORT_LATCH_RST);
    check("port_mode", {PORT_OPEN_DRAIN, PORT_PULLUP_EN, INT_OSC_SEL}, 3'b111);
    n = 0;
    repeat (24) begin
      @(posedge CORE_CLK);
      n += WDT_TICK;
    end
    check("wdt_ticks", n, 2);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    rd(OFS_CAUSE, 32'h2, RESP_OKAY);
    rd(OFS_MON, mon_exp(1'b1), RESP_OKAY);
    rd(12'h010, 32'h0, RESP_SLVERR);
    wr(12'h010, 32'h1, 4'hF, RESP_SLVERR);
    repeat (4) begin
      seed = xs(seed);
      if (seed[8]) en = seed[7];
      wr(OFS_MON, seed, seed[11:8], RESP_OKAY);
      rd(OFS_MON, mon_exp(en), RESP_OKAY);
    end
    wr(OFS_MON, 32'h0, 4'h1, RESP_OKAY);
    VDD_ABOVE_THRESHOLD <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    check("mon_off_no_reset", CORE_HALT, 1'b0);
    VDD_ABOVE_THRESHOLD <= 1'b1;
    wr(OFS_SWRST, 32'h1, 4'h1, RESP_OKAY);
    wait_halt(1'b1, n);
    wait_halt(1'b0, n);
    rd(OFS_CAUSE, 32'h10, RESP_OKAY);
    rd(OFS_MON, mon_exp(1'b0), RESP_OKAY);
    ext_low <= 1'b1;
    wait_halt(1'b1, n);
    ext_low <= 1'b0;
    wait_halt(1'b0, n);
    rd(OFS_CAUSE, 32'h1, RESP_OKAY);
    OTHER_RESET_REQ <= 1'b1;
    @(posedge CORE_CLK);
    OTHER_RESET_REQ <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    rd(OFS_CAUSE, 32'h0, RESP_OKAY);
    wr(OFS_MON, 32'h80, 4'h1, RESP_OKAY);
    VDD_ABOVE_THRESHOLD <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    check("mon_pin_drive", RESET_PIN_OE, 1'b1);
    check("mon_halt", CORE_HALT, 1'b1);
    VDD_ABOVE_THRESHOLD <= 1'b1;
    wait_halt(1'b0, n);
    check("mon_no_delay", n < 8, 1'b1);
    rd(OFS_MON, mon_exp(1'b1), RESP_OKAY);
    results();
  end
endmodule : mcu_reset_controller_tb
`default_nettype wire
